// file: rtl/pdos_flag_if.sv
// Carrier between the register slice and its sticky flag holder.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface pdos_flag_if;
    logic [4:0] set;
    logic       clear;
    logic [4:0] flags;

    modport holder (input set, input clear, output flags);
    modport user   (output set, output clear, input flags);
endinterface

// file: rtl/pdos_pkg.sv
// Constants and state types for the pin drive and overflow status slice.
// Assumes the importing modules run on one clock with a synchronous reset.
package pdos_pkg;

    // ----------------------------------------------------------------------
    // Register offsets on the control port
    // ----------------------------------------------------------------------
    localparam logic [7:0] PDOS_OFS_LEVEL    = 8'h56;
    localparam logic [7:0] PDOS_OFS_POLARITY = 8'h57;
    localparam logic [7:0] PDOS_OFS_STATUS   = 8'h5A;

    // ----------------------------------------------------------------------
    // Field layout and reset values
    // ----------------------------------------------------------------------
    localparam int         PDOS_PIN_LO       = 2;
    localparam int         PDOS_PIN_HI       = 5;
    localparam int         PDOS_NPINS        = 4;
    localparam int         PDOS_PIN_MUTE     = 4;
    localparam int         PDOS_PIN_THREE    = 5;
    localparam logic [7:0] PDOS_PIN_MASK     = 8'h3C;
    localparam logic [7:0] PDOS_LEVEL_RST    = 8'h00;
    localparam logic [7:0] PDOS_POLARITY_RST = 8'h00;
    localparam int         PDOS_NFLAGS       = 5;
    localparam int         PDOS_BIT_P1L      = 4;
    localparam int         PDOS_BIT_P1R      = 3;
    localparam int         PDOS_BIT_P2L      = 2;
    localparam int         PDOS_BIT_P2R      = 1;
    localparam int         PDOS_BIT_SHIFT    = 0;
    localparam logic [4:0] PDOS_FLAGS_RST    = 5'h00;

    // Source code that routes the register level onto a pin
    localparam logic [3:0] PDOS_SRC_REGISTER = 4'h2;

    // ----------------------------------------------------------------------
    // State types
    // ----------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] level;
        logic [7:0] polarity;
        logic [7:0] rdata;
        logic [3:0] drive;
    } pdos_state_t;

    typedef struct packed {
        logic [4:0] flags;
    } pdos_flag_state_t;

endpackage

// file: rtl/pdos_sticky_flags.sv
// Sticky event flags with a common clear strobe.
// Assumes set and clear are synchronous to clock_in.
`timescale 1ns/1ps
module pdos_sticky_flags
    import pdos_pkg::*;
(
    input  wire logic clock_in,       // System clock
    input  wire logic srst_in,        // Synchronous reset, active high
    pdos_flag_if.holder flag_bus      // Set, clear and flag values
);

    pdos_flag_state_t st_r;
    pdos_flag_state_t st_nxt;

    // ----------------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------------
    // Set is applied after the clear, so an event in the clear cycle stays
    always_comb begin
        st_nxt = st_r;
        if (flag_bus.clear) begin
            st_nxt.flags = '0;
        end
        st_nxt.flags = st_nxt.flags | flag_bus.set;
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            st_r.flags <= PDOS_FLAGS_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign flag_bus.flags = st_r.flags;

endmodule

// file: rtl/pdos_top.sv
// Pin level, pin polarity and overflow status registers.
// Assumes the control port presents one access per cycle, synchronous to
// clock_in, and that pin direction is set elsewhere.
`timescale 1ns/1ps

// How it works
// - Level bits 5..2 drive their pins while the selector picks code 2.
// - A level bit of 0 drives low, 1 drives high; level resets to 0.
// - A polarity bit of 1 inverts its pin for any source; resets to 0.
// - Status bit 4 sets on port one left overflow and holds until read.
// - Status bit 3 sets on port one right overflow and holds until read.
// - Status bit 2 sets on port two left overflow and holds until read.
// - Status bit 1 sets on port two right overflow and holds until read.
// - Status bit 0 sets on shifter overflow and holds until read.
// - Level bit 4 is the register level for the mute pin.
module pdos_top
    import pdos_pkg::*;
(
    input  wire logic        clock_in,          // System clock
    input  wire logic        srst_in,           // Synchronous reset
    input  wire logic [7:0]  reg_addr_in,       // Register offset
    input  wire logic        reg_wr_in,         // Write strobe
    input  wire logic [7:0]  reg_wdata_in,      // Write data
    input  wire logic        reg_rd_in,         // Read strobe
    output logic      [7:0]  reg_rdata_out,     // Read data, next cycle
    input  wire logic [4:0]  ovf_event_in,      // Overflow pulses, bit=flag
    input  wire logic [15:0] pin_src_sel_in,    // Selector codes, pins 5..2
    input  wire logic [3:0]  pin_src_level_in,  // Other source levels
    output logic      [3:0]  pin_drive_out      // Pin levels, pins 5..2
);

    pdos_state_t  st_r;
    pdos_state_t  st_nxt;
    pdos_flag_if  flag_bus ();

    logic         rd_status;

    // ----------------------------------------------------------------------
    // Sticky overflow flags
    // ----------------------------------------------------------------------
    pdos_sticky_flags u_flags (
        .clock_in (clock_in),
        .srst_in  (srst_in),
        .flag_bus (flag_bus)
    );

    assign rd_status      = reg_rd_in && (reg_addr_in == PDOS_OFS_STATUS);
    assign flag_bus.set   = ovf_event_in;
    assign flag_bus.clear = rd_status;

    // ----------------------------------------------------------------------
    // Register access and pin drive
    // ----------------------------------------------------------------------
    always_comb begin
        logic src;
        src    = 1'b0;
        st_nxt = st_r;
        if (reg_wr_in) begin
            // Reserved bits are dropped on write; status writes are ignored
            case (reg_addr_in)
                PDOS_OFS_LEVEL:
                    st_nxt.level = reg_wdata_in & PDOS_PIN_MASK;
                PDOS_OFS_POLARITY:
                    st_nxt.polarity = reg_wdata_in & PDOS_PIN_MASK;
                default: begin
                    st_nxt.level = st_nxt.level;
                end
            endcase
        end
        if (reg_rd_in) begin
            case (reg_addr_in)
                PDOS_OFS_LEVEL:    st_nxt.rdata = st_r.level;
                PDOS_OFS_POLARITY: st_nxt.rdata = st_r.polarity;
                PDOS_OFS_STATUS:   st_nxt.rdata = {3'h0, flag_bus.flags};
                default:           st_nxt.rdata = 8'h00;
            endcase
        end
        for (int i = 0; i < PDOS_NPINS; i++) begin
            if (pin_src_sel_in[i*4 +: 4] == PDOS_SRC_REGISTER) begin
                src = st_r.level[PDOS_PIN_LO + i];
            end else begin
                src = pin_src_level_in[i];
            end
            st_nxt.drive[i] = src ^ st_r.polarity[PDOS_PIN_LO + i];
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            st_r.level    <= PDOS_LEVEL_RST;
            st_r.polarity <= PDOS_POLARITY_RST;
            st_r.rdata    <= 8'h00;
            st_r.drive    <= 4'h0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_out = st_r.rdata;
    assign pin_drive_out = st_r.drive;

    // ----------------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------------
    property p_three_reg_level;
        @(posedge clock_in) disable iff (srst_in)
        (pin_src_sel_in[15:12] == PDOS_SRC_REGISTER)
            && !st_r.polarity[PDOS_PIN_THREE]
            |=> pin_drive_out[3] == $past(st_r.level[PDOS_PIN_THREE]);
    endproperty
    a_three_reg_level: assert property (p_three_reg_level)
        else $error("pin three does not follow its level bit");

    property p_level_write;
        @(posedge clock_in) disable iff (srst_in)
        reg_wr_in && (reg_addr_in == PDOS_OFS_LEVEL)
            ##1 reg_rd_in && (reg_addr_in == PDOS_OFS_LEVEL) && !reg_wr_in
            |=> reg_rdata_out == ($past(reg_wdata_in, 2) & PDOS_PIN_MASK);
    endproperty
    a_level_write: assert property (p_level_write)
        else $error("level register readback wrong");

    property p_invert;
        @(posedge clock_in) disable iff (srst_in)
        st_r.polarity[PDOS_PIN_LO]
            |=> pin_drive_out[0] != (
                ($past(pin_src_sel_in[3:0]) == PDOS_SRC_REGISTER)
                    ? $past(st_r.level[PDOS_PIN_LO])
                    : $past(pin_src_level_in[0]));
    endproperty
    a_invert: assert property (p_invert)
        else $error("pin two not inverted");

    property p_flag_p1l;
        @(posedge clock_in) disable iff (srst_in)
        ovf_event_in[PDOS_BIT_P1L] ##1 !rd_status[*2]
            |=> flag_bus.flags[PDOS_BIT_P1L];
    endproperty
    a_flag_p1l: assert property (p_flag_p1l)
        else $error("port one left flag not held");

    property p_flag_p1r;
        @(posedge clock_in) disable iff (srst_in)
        ovf_event_in[PDOS_BIT_P1R] |=> flag_bus.flags[PDOS_BIT_P1R];
    endproperty
    a_flag_p1r: assert property (p_flag_p1r)
        else $error("port one right flag not set");

    property p_flag_p2l;
        @(posedge clock_in) disable iff (srst_in)
        ovf_event_in[PDOS_BIT_P2L] |=> flag_bus.flags[PDOS_BIT_P2L];
    endproperty
    a_flag_p2l: assert property (p_flag_p2l)
        else $error("port two left flag not set");

    property p_flag_p2r;
        @(posedge clock_in) disable iff (srst_in)
        ovf_event_in[PDOS_BIT_P2R] |=> flag_bus.flags[PDOS_BIT_P2R];
    endproperty
    a_flag_p2r: assert property (p_flag_p2r)
        else $error("port two right flag not set");

    property p_read_clear;
        @(posedge clock_in) disable iff (srst_in)
        rd_status && !ovf_event_in[PDOS_BIT_SHIFT]
            |=> !flag_bus.flags[PDOS_BIT_SHIFT]
                && reg_rdata_out[PDOS_BIT_SHIFT]
                    == $past(flag_bus.flags[PDOS_BIT_SHIFT]);
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("shifter flag not returned and cleared on read");

    property p_mute_level;
        @(posedge clock_in) disable iff (srst_in)
        (pin_src_sel_in[11:8] == PDOS_SRC_REGISTER)
            |=> pin_drive_out[2] == ($past(st_r.level[PDOS_PIN_MUTE])
                ^ $past(st_r.polarity[PDOS_PIN_MUTE]));
    endproperty
    a_mute_level: assert property (p_mute_level)
        else $error("mute pin does not follow level bit four");

    property p_set_wins;
        @(posedge clock_in) disable iff (srst_in)
        rd_status && ovf_event_in[PDOS_BIT_P1L]
            |=> flag_bus.flags[PDOS_BIT_P1L];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("overflow lost during status read");

    property p_flag_shift;
        @(posedge clock_in) disable iff (srst_in)
        ovf_event_in[PDOS_BIT_SHIFT] |=> flag_bus.flags[PDOS_BIT_SHIFT];
    endproperty
    a_flag_shift: assert property (p_flag_shift)
        else $error("shifter flag not set");

    property p_status_wr;
        @(posedge clock_in) disable iff (srst_in)
        reg_wr_in && (reg_addr_in == PDOS_OFS_STATUS) && !reg_rd_in
            && (ovf_event_in == 5'h00)
            |=> flag_bus.flags == $past(flag_bus.flags);
    endproperty
    a_status_wr: assert property (p_status_wr)
        else $error("status write changed the flags");

    property p_level_store;
        @(posedge clock_in) disable iff (srst_in)
        reg_wr_in && (reg_addr_in == PDOS_OFS_LEVEL)
            |=> st_r.level == ($past(reg_wdata_in) & PDOS_PIN_MASK);
    endproperty
    a_level_store: assert property (p_level_store)
        else $error("level register did not take the write");

    property p_pol_store;
        @(posedge clock_in) disable iff (srst_in)
        reg_wr_in && (reg_addr_in == PDOS_OFS_POLARITY)
            |=> st_r.polarity == ($past(reg_wdata_in) & PDOS_PIN_MASK);
    endproperty
    a_pol_store: assert property (p_pol_store)
        else $error("polarity register did not take the write");

    // No disable here: this one must look at the cycles right after reset
    property p_reset_values;
        @(posedge clock_in)
        srst_in |=> (st_r.level == PDOS_LEVEL_RST)
            && (st_r.polarity == PDOS_POLARITY_RST)
            && (flag_bus.flags == PDOS_FLAGS_RST)
            && (pin_drive_out == 4'h0);
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("state not cleared by reset");

endmodule

// file: tb/pdos_top_test.sv
// Self-checking bench for the pin drive and overflow status slice.
// Assumes pdos_pkg and the design files are compiled first.
`timescale 1ns/1ps
module pdos_top_test;
    import pdos_pkg::*;

    logic        clock_in;
    logic        srst_in;
    logic [7:0]  reg_addr_in;
    logic        reg_wr_in;
    logic [7:0]  reg_wdata_in;
    logic        reg_rd_in;
    logic [7:0]  reg_rdata_out;
    logic [4:0]  ovf_event_in;
    logic [15:0] pin_src_sel_in;
    logic [3:0]  pin_src_level_in;
    logic [3:0]  pin_drive_out;
    int          miscompares;
    int          total_checks;
    integer      seed;
    logic [7:0]  lvl;
    logic [7:0]  pol;
    logic [15:0] sel;
    logic [3:0]  src;
    logic [4:0]  ev_a;
    logic [4:0]  ev_b;
    logic [3:0]  pe;

    pdos_top i_pdos_top (
        .clock_in         (clock_in),
        .srst_in          (srst_in),
        .reg_addr_in      (reg_addr_in),
        .reg_wr_in        (reg_wr_in),
        .reg_wdata_in     (reg_wdata_in),
        .reg_rd_in        (reg_rd_in),
        .reg_rdata_out    (reg_rdata_out),
        .ovf_event_in     (ovf_event_in),
        .pin_src_sel_in   (pin_src_sel_in),
        .pin_src_level_in (pin_src_level_in),
        .pin_drive_out    (pin_drive_out)
    );

    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check8(input logic [7:0] got, input logic [7:0] exp,
                          input string what);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        reg_wr_in    <= 1'b1;
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        @(posedge clock_in);
        reg_wr_in    <= 1'b0;
    endtask

    // Read data is checked just after the edge that takes the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp,
                          input string what);
        @(posedge clock_in);
        reg_rd_in   <= 1'b1;
        reg_addr_in <= a;
        @(posedge clock_in);
        reg_rd_in   <= 1'b0;
        #1;
        check8(reg_rdata_out, exp, what);
    endtask

    task automatic pulse(input logic [4:0] v);
        @(posedge clock_in);
        ovf_event_in <= v;
        @(posedge clock_in);
        ovf_event_in <= 5'h00;
    endtask

    // One overflow bit at a time: set, held while idle, cleared by a read
    task automatic flag_round(input int k);
        logic [7:0] fl;
        fl = 8'(1 << k);
        pulse(5'(fl));
        repeat (4) @(posedge clock_in);
        rd_chk(PDOS_OFS_STATUS, fl, "held");
        fl = 8'h00;
        rd_chk(PDOS_OFS_STATUS, fl, "clr");
    endtask

    function automatic logic [3:0] pin_exp(input logic [7:0] lv,
        input logic [7:0] pl, input logic [15:0] sl, input logic [3:0] sr);
        logic [3:0] r;
        for (int i = 0; i < PDOS_NPINS; i++)
            r[i] = ((sl[4*i +: 4] == PDOS_SRC_REGISTER) ?
                    lv[PDOS_PIN_LO+i] : sr[i]) ^ pl[PDOS_PIN_LO+i];
        return r;
    endfunction

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        seed = 32'h7B6C;
        miscompares = 0;
        total_checks = 0;
        srst_in = 1'b1;
        reg_addr_in = 8'h00;
        reg_wr_in = 1'b0;
        reg_wdata_in = 8'h00;
        reg_rd_in = 1'b0;
        ovf_event_in = 5'h00;
        pin_src_sel_in = 16'h0000;
        pin_src_level_in = 4'h0;
        repeat (3) @(posedge clock_in);
        srst_in <= 1'b0;
        @(posedge clock_in);
        #1;
        check8({4'h0, pin_drive_out}, 8'h00, "pin reset");
        rd_chk(PDOS_OFS_LEVEL, PDOS_LEVEL_RST, "level reset");
        rd_chk(PDOS_OFS_POLARITY, PDOS_POLARITY_RST, "pol reset");
        rd_chk(PDOS_OFS_STATUS, 8'h00, "status reset");
        wr(PDOS_OFS_STATUS, 8'hFF);
        rd_chk(PDOS_OFS_STATUS, 8'h00, "status written");
        rd_chk(8'h58, 8'h00, "unmapped read");
        // Write then read on the next cycle; reserved bits must drop away
        @(posedge clock_in);
        reg_wr_in    <= 1'b1;
        reg_addr_in  <= PDOS_OFS_LEVEL;
        reg_wdata_in <= 8'hFF;
        @(posedge clock_in);
        reg_wr_in    <= 1'b0;
        reg_rd_in    <= 1'b1;
        @(posedge clock_in);
        reg_rd_in    <= 1'b0;
        #1;
        check8(reg_rdata_out, PDOS_PIN_MASK, "back to back");
        // First pass is the corner: all pins on register source, all inverted
        for (int n = 0; n < 40; n++) begin
            lvl = 8'($random(seed)) & PDOS_PIN_MASK;
            pol = 8'($random(seed)) & PDOS_PIN_MASK;
            src = 4'($random(seed));
            for (int p = 0; p < PDOS_NPINS; p++)
                sel[4*p +: 4] = ($random(seed) & 1) ? PDOS_SRC_REGISTER
                                                    : 4'($random(seed));
            if (n == 0) begin
                lvl = PDOS_PIN_MASK;
                pol = PDOS_PIN_MASK;
                sel = 16'h2222;
            end
            wr(PDOS_OFS_LEVEL, lvl);
            wr(PDOS_OFS_POLARITY, pol);
            pin_src_sel_in   <= sel;
            pin_src_level_in <= src;
            pe = pin_exp(lvl, pol, sel, src);
            repeat (3) @(posedge clock_in);
            #1;
            check8({4'h0, pin_drive_out}, {4'h0, pe}, "pins");
            rd_chk(PDOS_OFS_LEVEL, lvl, "level");
            rd_chk(PDOS_OFS_POLARITY, pol, "polarity");
        end
        for (int k = 0; k < PDOS_NFLAGS; k++) begin
            flag_round(k);
        end
        // Event landing on the clearing read must survive it
        pulse(5'h11);
        @(posedge clock_in);
        reg_rd_in    <= 1'b1;
        reg_addr_in  <= PDOS_OFS_STATUS;
        ovf_event_in <= 5'h10;
        @(posedge clock_in);
        reg_rd_in    <= 1'b0;
        ovf_event_in <= 5'h00;
        #1;
        check8(reg_rdata_out, 8'h11, "flags before clear");
        rd_chk(PDOS_OFS_STATUS, 8'h10, "set beats clear");
        for (int n = 0; n < 8; n++) begin
            ev_a = 5'($random(seed));
            ev_b = 5'($random(seed));
            pulse(ev_a);
            pulse(ev_b);
            rd_chk(PDOS_OFS_STATUS, {3'h0, ev_a | ev_b}, "sum");
        end
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge clock_in);
        miscompares++;
        $display("BAD %0t run did not finish", $time);
        wrap_up();
    end
endmodule
